/* nvm_ctrl_pkg.sv */
// Constants and types shared by the configuration memory controller
package nvm_ctrl_pkg;
    // --------------------------------------------------------------
    // Memory geometry
    // --------------------------------------------------------------
    localparam int NVM_BITS    = 75;
    localparam int SLICE_W     = 10;
    localparam int SLICE_SEL_W = 3;
    localparam int LOCK_POS    = 74;
    localparam int TOP_SLICE   = 7;
    localparam int TOP_BITS    = 5;

    // --------------------------------------------------------------
    // Operation select encodings
    // --------------------------------------------------------------
    localparam logic [1:0] OP_NOP0    = 2'h0;
    localparam logic [1:0] OP_REFRESH = 2'h1;
    localparam logic [1:0] OP_BURN    = 2'h2;
    localparam logic [1:0] OP_NOP3    = 2'h3;

    // --------------------------------------------------------------
    // Timing
    // --------------------------------------------------------------
    localparam int CLK_MHZ          = 200;
    localparam int REFRESH_US       = 46;
    localparam int BURN_MS          = 15;
    localparam int REFRESH_CYCLES   = REFRESH_US * CLK_MHZ;
    localparam int BURN_CYCLES      = BURN_MS * 1000 * CLK_MHZ;
    localparam int CNT_W            = 22;

    // --------------------------------------------------------------
    // Reset values
    // --------------------------------------------------------------
    localparam logic [NVM_BITS-1:0] NVM_RST  = 75'h0;
    localparam logic [SLICE_W-1:0]  DATA_RST = 10'h000;

    // Sequencer states
    typedef enum logic [1:0] {
        ST_IDLE    = 2'b00,
        ST_REFRESH = 2'b01,
        ST_BURN    = 2'b10
    } op_state_t;
endpackage : nvm_ctrl_pkg

/* nvm_slice_mux.sv */
// Selects one 10-bit slice of the reloaded memory image
`timescale 1ns/100ps
`default_nettype none
module nvm_slice_mux (
    // Image and selector
    input  wire logic [nvm_ctrl_pkg::NVM_BITS-1:0]    image,
    input  wire logic [nvm_ctrl_pkg::SLICE_SEL_W-1:0] sel,
    // Slice
    output logic      [nvm_ctrl_pkg::SLICE_W-1:0]     slice
);
    import nvm_ctrl_pkg::*;

    logic [SLICE_W-1:0] slices [0:TOP_SLICE];

    genvar g;
    generate
        for (g = 0; g < TOP_SLICE; g++) begin : g_slice
            assign slices[g] = image[g*SLICE_W +: SLICE_W];
        end
    endgenerate
    // Top slice pads five zeros above bits 74..70
    assign slices[TOP_SLICE] = {{(SLICE_W-TOP_BITS){1'b0}},
                                image[NVM_BITS-1 -: TOP_BITS]};

    assign slice = slices[sel];
endmodule : nvm_slice_mux
`default_nettype wire

/* nvm_operation_controller.sv */
// One-time-programmable configuration memory operation controller
// ------------------------------------------------------------------
// ------------------------------------------------------------------
`timescale 1ns/100ps
`default_nettype none
module nvm_operation_controller #(
    parameter int BURN_CNT = nvm_ctrl_pkg::BURN_CYCLES
) (
    // Clock and reset
    input  wire logic                                 core_clk,
    input  wire logic                                 sys_rst,
    // Serial register side
    input  wire logic                                 chip_select_n,
    input  wire logic                                 op_write,
    input  wire logic [1:0]                           op_select,
    input  wire logic [nvm_ctrl_pkg::SLICE_SEL_W-1:0] slice_select,
    input  wire logic                                 bias_low,
    input  wire logic                                 bias_high,
    input  wire logic [nvm_ctrl_pkg::NVM_BITS-2:0]    config_image,
    input  wire logic                                 status_read,
    // Analog supply monitor
    input  wire logic                                 burn_supply_low_threshold,
    // Memory array port
    input  wire logic [nvm_ctrl_pkg::NVM_BITS-1:0]    array_rdata,
    output logic                                      array_read,
    output logic                                      array_burn,
    output logic      [nvm_ctrl_pkg::NVM_BITS-1:0]    array_wdata,
    output logic      [1:0]                           array_margin,
    // Status
    output logic                                      op_busy,
    output logic                                      burn_fail,
    output logic                                      burn_refused,
    output logic      [nvm_ctrl_pkg::SLICE_W-1:0]     read_word
);
    import nvm_ctrl_pkg::*;

    // ------------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------------
    logic       cs_meta;
    logic       cs_sync;
    logic       cs_prev;
    logic       uv_meta;
    logic       uv_sync;
    logic       cs_rise;

    // Two flops for chip select, a third for edge detection
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            cs_meta <= 1'b1;
            cs_sync <= 1'b1;
            cs_prev <= 1'b1;
        end else begin
            cs_meta <= chip_select_n;
            cs_sync <= cs_meta;
            cs_prev <= cs_sync;
        end
    end

    // Two flops for the supply comparator
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            uv_meta <= 1'b0;
            uv_sync <= 1'b0;
        end else begin
            uv_meta <= burn_supply_low_threshold;
            uv_sync <= uv_meta;
        end
    end

    // Idle-high reset values keep a false edge out after reset
    assign cs_rise = cs_sync & ~cs_prev;

    // ------------------------------------------------------------------
    // Command latch
    // ------------------------------------------------------------------
    logic [1:0] cmd;
    logic       cmd_valid;

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            cmd       <= OP_NOP0;
            cmd_valid <= 1'b0;
        end else if (op_write) begin
            cmd       <= op_select;
            cmd_valid <= 1'b1;
        end else if (cs_rise) begin
            cmd_valid <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Command decode
    // ------------------------------------------------------------------
    logic       cmd_fire;
    logic       is_refresh;
    logic       is_burn;

    // Pending command meets the end of its frame
    assign cmd_fire = cs_rise & cmd_valid;

    // Codes 0 and 3 decode to nothing
    always_comb begin
        is_refresh = 1'b0;
        is_burn    = 1'b0;
        if (cmd == OP_REFRESH) begin
            is_refresh = 1'b1;
        end else if (cmd == OP_BURN) begin
            is_burn = 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------------
    op_state_t            state;
    op_state_t            next_state;
    logic [CNT_W-1:0]     cnt;
    logic [NVM_BITS-1:0]  image;
    logic                 locked;
    logic                 start_refresh;
    logic                 start_burn;
    logic                 last_cycle;
    logic                 refresh_end;
    logic                 burn_end;

    assign locked = image[LOCK_POS];

    // Start on the frame-closing edge when idle; a burn also needs the lock bit clear
    assign start_refresh = cmd_fire & is_refresh & (state == ST_IDLE);
    assign start_burn    = cmd_fire & is_burn & (state == ST_IDLE) & ~locked;
    assign last_cycle    = (cnt == CNT_W'(1));

    // Operation ends on the last counted cycle
    assign refresh_end   = (state == ST_REFRESH) & last_cycle;
    assign burn_end      = (state == ST_BURN) & last_cycle;

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (start_refresh) begin
                    next_state = ST_REFRESH;
                end else if (start_burn) begin
                    next_state = ST_BURN;
                end
            end
            ST_REFRESH: begin
                if (last_cycle) begin
                    next_state = ST_IDLE;
                end
            end
            ST_BURN: begin
                if (last_cycle) begin
                    next_state = ST_IDLE;
                end
            end
            default: next_state = ST_IDLE;
        endcase
    end

    // State register
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            state <= ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // ------------------------------------------------------------------
    // Duration counter
    // ------------------------------------------------------------------
    // Operation duration counter, shared by refresh and burn
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            cnt <= '0;
        end else if (start_refresh) begin
            cnt <= CNT_W'(REFRESH_CYCLES);
        end else if (start_burn) begin
            cnt <= CNT_W'(BURN_CNT);
        end else if (cnt != '0) begin
            cnt <= cnt - CNT_W'(1);
        end
    end

    // ------------------------------------------------------------------
    // Burn refusal
    // ------------------------------------------------------------------
    // Refused burn indication
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            burn_refused <= 1'b0;
        end else if (cmd_fire & is_burn) begin
            burn_refused <= locked | (state != ST_IDLE);
        end
    end

    // ------------------------------------------------------------------
    // Array drive
    // ------------------------------------------------------------------
    // Burn config with lock bit set
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            array_wdata <= NVM_RST;
        end else if (start_burn) begin
            array_wdata <= {1'b1, config_image};
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            array_margin <= 2'h0;
        end else if (start_refresh) begin
            array_margin <= {bias_high, bias_low};
        end else if (next_state != ST_REFRESH) begin
            array_margin <= 2'h0;               // Drops with the refresh end
        end
    end

    // ------------------------------------------------------------------
    // Array strobes and status outputs
    // ------------------------------------------------------------------
    // Array strobes follow the state register
    assign array_read = (state == ST_REFRESH);
    assign array_burn = (state == ST_BURN);

    assign op_busy = (state != ST_IDLE);

    // ------------------------------------------------------------------
    // Image register
    // ------------------------------------------------------------------
    // Capture image at refresh end
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            image <= NVM_RST;
        end else if (refresh_end) begin
            image <= array_rdata;
        end else if (burn_end) begin
            image[LOCK_POS] <= 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // Failure flag
    // ------------------------------------------------------------------
    // Set wins over read clear
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            burn_fail <= 1'b0;
        end else if ((state == ST_BURN) && uv_sync) begin
            burn_fail <= 1'b1;
        end else if (status_read) begin
            burn_fail <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Read word
    // ------------------------------------------------------------------
    logic [SLICE_W-1:0] slice;

    nvm_slice_mux u_mux (
        .image (image),
        .sel   (slice_select),
        .slice (slice)
    );

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            read_word <= DATA_RST;
        end else if (state == ST_IDLE) begin
            read_word <= slice;
        end
    end
endmodule : nvm_operation_controller
`default_nettype wire

/* nvm_op_checker.sv */
// Port checker for the memory operation controller
`timescale 1ns/100ps
`default_nettype none
module nvm_op_checker #(
    parameter int BURN_CNT = 20
) (
    // Clock and reset
    input  wire logic        core_clk,
    input  wire logic        sys_rst,
    // Host side
    input  wire logic        chip_select_n,
    input  wire logic        bias_low,
    input  wire logic        bias_high,
    input  wire logic        status_read,
    input  wire logic        burn_supply_low_threshold,
    // Array side and status
    input  wire logic        array_read,
    input  wire logic        array_burn,
    input  wire logic [74:0] array_wdata,
    input  wire logic [1:0]  array_margin,
    input  wire logic        op_busy,
    input  wire logic        burn_fail,
    input  wire logic [9:0]  read_word
);
    import nvm_ctrl_pkg::*;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    logic [31:0] busy_cnt;
    logic        burned;
    // Busy cycle count
    always_ff @(posedge core_clk) begin
        if (sys_rst || !op_busy)
            busy_cnt <= 32'h0;
        else
            busy_cnt <= busy_cnt + 32'h1;
    end
    // Remembers a started burn
    always_ff @(posedge core_clk) begin
        if (sys_rst)
            burned <= 1'b0;
        else if (array_burn)
            burned <= 1'b1;
    end
    sequence s_run;
        op_busy [*8];
    endsequence
    sequence s_quiet_read;
        (!op_busy) [*5] ##0 (status_read && !burn_supply_low_threshold);
    endsequence
    start_after_cs_a: assert property (
        $rose(op_busy) |-> $past(chip_select_n) ##0 s_run)
        else $error("operation started without chip select release");
    refresh_len_a: assert property (
        $fell(op_busy) && $past(array_read) |-> busy_cnt == REFRESH_CYCLES)
        else $error("refresh length wrong");
    burn_len_a: assert property (
        $fell(op_busy) && $past(array_burn) |-> busy_cnt == BURN_CNT)
        else $error("burn length wrong");
    busy_match_a: assert property (op_busy == (array_read || array_burn))
        else $error("busy does not match running operation");
    margin_start_a: assert property (
        $rose(array_read) |-> array_margin == {$past(bias_high), $past(bias_low)})
        else $error("margin bias not applied at refresh");
    margin_idle_a: assert property (!array_read |-> array_margin == 2'h0)
        else $error("margin bias outside refresh");
    lock_written_a: assert property (array_burn |-> array_wdata[LOCK_POS])
        else $error("lock bit not burned");
    burn_once_a: assert property (burned |-> !$rose(array_burn))
        else $error("second burn started");
    word_hold_a: assert property (op_busy && $past(op_busy) |-> $stable(read_word))
        else $error("read word moved during operation");
    fail_clear_a: assert property (s_quiet_read |=> !burn_fail)
        else $error("failure flag not cleared by read");
    fail_set_a: assert property (
        array_burn && $past(burn_supply_low_threshold, 2) |=> burn_fail)
        else $error("undervoltage during burn not flagged");
endmodule : nvm_op_checker
bind nvm_operation_controller nvm_op_checker #(.BURN_CNT(BURN_CNT)) op_chk (
    .core_clk(core_clk), .sys_rst(sys_rst), .chip_select_n(chip_select_n),
    .bias_low(bias_low), .bias_high(bias_high), .status_read(status_read),
    .burn_supply_low_threshold(burn_supply_low_threshold), .array_read(array_read),
    .array_burn(array_burn), .array_wdata(array_wdata), .array_margin(array_margin),
    .op_busy(op_busy), .burn_fail(burn_fail), .read_word(read_word));
`default_nettype wire

/* nvm_array_model.sv */
// Behavioural one-time memory array behind the controller
`timescale 1ns/100ps
`default_nettype none
module nvm_array_model (
    // Clock
    input  wire logic        core_clk,
    // Array port
    input  wire logic        array_read,
    input  wire logic        array_burn,
    input  wire logic [74:0] array_wdata,
    output logic      [74:0] array_rdata
);
    logic [74:0] cells;
    initial cells = 75'h0;
    always @(posedge core_clk) begin
        if (array_burn)
            cells <= cells | array_wdata;
    end
    assign array_rdata = array_read ? cells : ~cells;
endmodule : nvm_array_model
`default_nettype wire

/* nvm_operation_controller_tb_top.sv */
// Self-checking bench for the memory operation controller
`timescale 1ns/100ps
`default_nettype none
module nvm_operation_controller_tb_top;
    import nvm_ctrl_pkg::*;
    logic        core_clk, sys_rst, chip_select_n, op_write, status_read;
    logic        bias_low, bias_high, burn_supply_low_threshold, seen;
    logic        array_read, array_burn, op_busy, burn_fail, burn_refused;
    logic [1:0]  op_select, array_margin;
    logic [2:0]  slice_select;
    logic [9:0]  read_word;
    logic [73:0] config_image;
    logic [74:0] array_rdata, array_wdata, exp_img;
    logic [31:0] seed;
    integer      error_cnt, check_count, k;
    nvm_operation_controller #(.BURN_CNT(20)) dut (.core_clk(core_clk), .sys_rst(sys_rst),
        .chip_select_n(chip_select_n), .op_write(op_write), .op_select(op_select),
        .slice_select(slice_select), .bias_low(bias_low), .bias_high(bias_high),
        .config_image(config_image), .status_read(status_read),
        .burn_supply_low_threshold(burn_supply_low_threshold), .array_rdata(array_rdata),
        .array_read(array_read), .array_burn(array_burn), .array_wdata(array_wdata),
        .array_margin(array_margin), .op_busy(op_busy), .burn_fail(burn_fail),
        .burn_refused(burn_refused), .read_word(read_word));
    nvm_array_model mem (.core_clk(core_clk), .array_read(array_read),
        .array_burn(array_burn), .array_wdata(array_wdata), .array_rdata(array_rdata));
    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    task automatic tick(input integer n);
        repeat (n) @(negedge core_clk);
    endtask : tick
    task automatic chk(input logic [74:0] got, input logic [74:0] exp);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic print_verdict;
        $display("errors=%0d checks=%0d", error_cnt, check_count);
        if (error_cnt == 0 && check_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : print_verdict
    // One command frame, then bounded wait for the operation to end
    task automatic op(input logic [1:0] c);
        integer i;
        op_write = 1'b1;
        op_select = c;
        chip_select_n = 1'b0;
        tick(1);
        op_write = 1'b0;
        tick(1);
        chip_select_n = 1'b1;
        seen = 1'b0;
        for (i = 0; i < 12000 && !(seen && op_busy === 1'b0) && (seen || i < 9); i++) begin
            tick(1);
            if (op_busy === 1'b1)
                seen = 1'b1;
        end
        if (i == 12000) begin
            error_cnt++;
            print_verdict();
        end
        tick(3);
    endtask : op
    // Walks every slice index against the expected image
    task automatic read_all;
        integer j;
        for (j = 0; j < 8; j++) begin
            slice_select = j[2:0];
            tick(3);
            chk(read_word, j < 7 ? exp_img[j*10 +: 10] : {5'h0, exp_img[74:70]});
        end
    endtask : read_all
    initial begin
        sys_rst = 1'b1;
        chip_select_n = 1'b1;
        op_write = 1'b0;
        op_select = 2'h0;
        slice_select = 3'h0;
        bias_low = 1'b1;
        bias_high = 1'b0;
        status_read = 1'b0;
        burn_supply_low_threshold = 1'b0;
        config_image = 74'h0;
        exp_img = 75'h0;
        seed = 32'h1a30;
        error_cnt = 0;
        check_count = 0;
        tick(3);
        sys_rst = 1'b0;
        tick(4);
        op(OP_NOP0);
        chk(seen, 1'b0);
        op(OP_NOP3);
        chk({seen, read_word}, 11'h0);
        op(OP_REFRESH);
        chk(seen, 1'b1);
        read_all();
        burn_supply_low_threshold = 1'b1;
        tick(6);
        chk(burn_fail, 1'b0);
        for (k = 0; k < 3; k++) begin
            seed = lfsr(seed);
            config_image = {config_image[41:0], seed};
        end
        exp_img = {1'b1, config_image};
        op(OP_BURN);
        chk({seen, burn_fail, burn_refused}, 3'h6);
        burn_supply_low_threshold = 1'b0;
        tick(2);
        chk(burn_fail, 1'b1);
        status_read = 1'b1;
        tick(1);
        status_read = 1'b0;
        tick(1);
        chk(burn_fail, 1'b0);
        // margin verification under both bias settings
        for (k = 0; k < 2; k++) begin
            bias_low = ~k[0];
            bias_high = k[0];
            op(OP_REFRESH);
            read_all();
        end
        seed = lfsr(seed);
        config_image = ~config_image ^ {42'h0, seed};
        op(OP_BURN);
        chk({seen, burn_refused}, 2'h1);
        op(OP_REFRESH);
        read_all();
        print_verdict();
    end
endmodule : nvm_operation_controller_tb_top
`default_nettype wire
